// ===== include/pdrom_pkg.sv
package pdrom_pkg;
   localparam int          PROG_DEPTH      = 4096;
   localparam int          PROG_AW         = 12;
   localparam int          PROG_DW         = 12;
   localparam logic [11:0] PROG_TOP        = 12'hfff;
   localparam logic [11:0] PROG_RSV_BASE   = 12'hf00;
   localparam logic [11:0] VEC_RESET       = 12'h000;
   localparam logic [11:0] VEC_WAKEUP      = 12'h004;
   localparam logic [11:0] VEC_INTERRUPT   = 12'h008;
   localparam logic [11:0] USER_CODE_BASE  = 12'h00a;
   localparam logic [11:0] FILL_ONES       = 12'hfff;
   localparam logic [11:0] FILL_ZEROS      = 12'h000;
   localparam int          DATA_DEPTH      = 57344;
   localparam int          DATA_AW         = 16;
   localparam logic [15:0] DATA_SYS_BASE   = 16'hdfc0;
   localparam logic [7:0]  DATA_RESET      = 8'h00;
   localparam logic [3:0]  NIB_RESET       = 4'h0;
   localparam int          TDRR_FSYS       = 2;
   localparam logic [1:0]  TDRR_CYC        = 2'(TDRR_FSYS);
   typedef enum logic [1:0] {
      PDROM_IDLE  = 2'b00,
      PDROM_ADDR  = 2'b01,
      PDROM_READ  = 2'b11
   } pdrom_state_t;
endpackage : pdrom_pkg

// ===== rtl/pdrom_prog_mem.sv
`timescale 1ns/1ps
module pdrom_prog_mem (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        unused_fill_ones_option,
   input  wire logic        prog_we,
   input  wire logic [11:0] prog_waddr,
   input  wire logic [11:0] prog_wdata,
   input  wire logic [11:0] prog_raddr,
   output logic      [11:0] prog_rdata
);
   logic [11:0] mem_q [pdrom_pkg::PROG_DEPTH];
   logic [11:0] mem_d [pdrom_pkg::PROG_DEPTH];
   logic [11:0] rdata_d;
   logic [11:0] rdata_q;
   logic        fill_q;
   logic        fill_d;
   logic        seen_q;
   logic        seen_d;

   // Fill option is caught once after reset release, never under the async reset
   always_comb begin
      seen_d = 1'b1;
      fill_d = seen_q ? fill_q : unused_fill_ones_option;
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         seen_q <= 1'b0;
         fill_q <= 1'b0;
      end else begin
         seen_q <= seen_d;
         fill_q <= fill_d;
      end
   end

   // Storage is loaded by the programming path; unwritten words take the fill pattern
   genvar i;
   for (i = 0; i < pdrom_pkg::PROG_DEPTH; i++) begin : g_word
      always_comb begin
         mem_d[i] = mem_q[i];
         if (!seen_q) begin
            mem_d[i] = unused_fill_ones_option ? pdrom_pkg::FILL_ONES : pdrom_pkg::FILL_ZEROS;
         end else if (prog_we && prog_waddr == 12'(i)) begin
            mem_d[i] = prog_wdata;
         end
      end
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            mem_q[i] <= pdrom_pkg::FILL_ZEROS;
         end else begin
            mem_q[i] <= mem_d[i];
         end
      end
   end

   // Reserved top region is not guarded, the assembler keeps code out of it
   always_comb begin
      rdata_d = mem_q[prog_raddr];
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_q <= pdrom_pkg::FILL_ZEROS;
      end else begin
         rdata_q <= rdata_d;
      end
   end
   assign prog_rdata = rdata_q;

   a_fill_pattern: assert property (@(posedge mclk) disable iff (rst)
      $rose(seen_q) |-> (mem_q[pdrom_pkg::PROG_TOP] == (fill_q ? pdrom_pkg::FILL_ONES : pdrom_pkg::FILL_ZEROS)))
      else $error("fill pattern wrong");
   a_prog_read: assert property (@(posedge mclk) disable iff (rst)
      seen_q && !prog_we |=> prog_rdata == $past(mem_q[prog_raddr]))
      else $error("program read wrong");
endmodule : pdrom_prog_mem

// ===== rtl/pdrom_top.sv
`timescale 1ns/1ps
module pdrom_top (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        unused_fill_ones_option,
   input  wire logic        prog_we,
   input  wire logic [11:0] prog_waddr,
   input  wire logic [11:0] prog_wdata,
   input  wire logic        fetch_reset,
   input  wire logic        fetch_wakeup,
   input  wire logic        fetch_interrupt,
   input  wire logic        fetch_next,
   output logic      [11:0] fetch_addr,
   output logic      [11:0] fetch_word,
   input  wire logic        rom_addr_we,
   input  wire logic [1:0]  rom_addr_sel,
   input  wire logic [3:0]  rom_addr_wdata,
   output logic      [3:0]  rom_addr_nibble0,
   output logic      [3:0]  rom_addr_nibble1,
   output logic      [3:0]  rom_addr_nibble2,
   output logic      [3:0]  rom_addr_nibble3,
   output logic      [15:0] data_memory_rom_addr,
   input  wire logic [7:0]  data_memory_rom_rdata,
   output logic      [3:0]  rom_byte_low_nibble,
   output logic      [3:0]  rom_byte_high_nibble,
   output logic             rom_data_ready
);
   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Program counter with vector selection
   logic [11:0] pc_q;
   logic [11:0] pc_d;

   always_comb begin
      pc_d = pc_q;
      if (fetch_reset) begin
         pc_d = pdrom_pkg::VEC_RESET;
      end else if (fetch_wakeup) begin
         pc_d = pdrom_pkg::VEC_WAKEUP;
      end else if (fetch_interrupt) begin
         pc_d = pdrom_pkg::VEC_INTERRUPT;
      end else if (fetch_next) begin
         pc_d = pc_q + 12'h001;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pc_q <= pdrom_pkg::VEC_RESET;
      end else begin
         pc_q <= pc_d;
      end
   end
   assign fetch_addr = pc_q;

   pdrom_prog_mem u_prog (
      .mclk                    (mclk),
      .rst                     (rst),
      .unused_fill_ones_option (unused_fill_ones_option),
      .prog_we                 (prog_we),
      .prog_waddr              (prog_waddr),
      .prog_wdata              (prog_wdata),
      .prog_raddr              (pc_q),
      .prog_rdata              (fetch_word)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Address nibble registers
   logic [3:0] nib_q [4];
   logic [3:0] nib_d [4];

   genvar k;
   for (k = 0; k < 4; k++) begin : g_nib
      always_comb begin
         nib_d[k] = nib_q[k];
         if (rom_addr_we && rom_addr_sel == 2'(k)) begin
            nib_d[k] = rom_addr_wdata;
         end
      end
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            nib_q[k] <= pdrom_pkg::NIB_RESET;
         end else begin
            nib_q[k] <= nib_d[k];
         end
      end
   end
   assign rom_addr_nibble0     = nib_q[0];
   assign rom_addr_nibble1     = nib_q[1];
   assign rom_addr_nibble2     = nib_q[2];
   assign rom_addr_nibble3     = nib_q[3];
   // System area at the top is not blocked, user data simply must not live there
   assign data_memory_rom_addr = {nib_q[3], nib_q[2], nib_q[1], nib_q[0]};

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Fetch sequencer: address settles, then the byte is captured
   pdrom_pkg::pdrom_state_t st_q;
   pdrom_pkg::pdrom_state_t st_d;
   logic [7:0]              byte_q;
   logic [7:0]              byte_d;

   always_comb begin
      st_d   = st_q;
      byte_d = byte_q;
      case (st_q)
         pdrom_pkg::PDROM_IDLE: begin
            st_d = pdrom_pkg::PDROM_IDLE;
         end
         pdrom_pkg::PDROM_ADDR: begin
            st_d = pdrom_pkg::PDROM_READ;
         end
         pdrom_pkg::PDROM_READ: begin
            if (!rom_addr_we) begin
               byte_d = data_memory_rom_rdata;
            end
            st_d   = pdrom_pkg::PDROM_IDLE;
         end
         default: begin
            st_d = pdrom_pkg::PDROM_IDLE;
         end
      endcase
      // A new write aborts any fetch in flight so stale bytes never land
      if (rom_addr_we) begin
         st_d = pdrom_pkg::PDROM_ADDR;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q   <= pdrom_pkg::PDROM_IDLE;
         byte_q <= pdrom_pkg::DATA_RESET;
      end else begin
         st_q   <= st_d;
         byte_q <= byte_d;
      end
   end
   assign rom_byte_low_nibble  = byte_q[3:0];
   assign rom_byte_high_nibble = byte_q[7:4];
   assign rom_data_ready       = (st_q == pdrom_pkg::PDROM_IDLE);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   a_vec_reset: assert property (@(posedge mclk) disable iff (rst)
      fetch_reset |=> fetch_addr == 12'h000) else $error("reset vector wrong");
   a_vec_wakeup: assert property (@(posedge mclk) disable iff (rst)
      !fetch_reset && fetch_wakeup |=> fetch_addr == 12'h004) else $error("wakeup vector wrong");
   a_vec_irq: assert property (@(posedge mclk) disable iff (rst)
      !fetch_reset && !fetch_wakeup && fetch_interrupt |=> fetch_addr == 12'h008)
      else $error("interrupt vector wrong");
   a_addr_form: assert property (@(posedge mclk) disable iff (rst)
      rom_addr_we && rom_addr_sel == 2'b11 |=> data_memory_rom_addr[15:12] == $past(rom_addr_wdata))
      else $error("high nibble wrong");
   a_addr_low: assert property (@(posedge mclk) disable iff (rst)
      rom_addr_we && rom_addr_sel == 2'b00 |=> rom_addr_nibble0 == $past(rom_addr_wdata))
      else $error("low nibble wrong");
   a_data_ready: assert property (@(posedge mclk) disable iff (rst)
      rom_addr_we ##1 !rom_addr_we ##1 !rom_addr_we |=> rom_data_ready && $past(!rom_data_ready))
      else $error("data late");
   a_data_byte: assert property (@(posedge mclk) disable iff (rst)
      st_q == pdrom_pkg::PDROM_READ && !rom_addr_we |=>
      {rom_byte_high_nibble, rom_byte_low_nibble} == $past(data_memory_rom_rdata))
      else $error("data byte wrong");
   a_data_hold: assert property (@(posedge mclk) disable iff (rst)
      st_q != pdrom_pkg::PDROM_READ |=> $stable(byte_q)) else $error("data changed");
   c_fetch_done: cover property (@(posedge mclk) disable iff (rst) rom_addr_we ##3 rom_data_ready);
   c_restart: cover property (@(posedge mclk) disable iff (rst) rom_addr_we ##1 rom_addr_we);
   c_irq: cover property (@(posedge mclk) disable iff (rst) fetch_interrupt);
endmodule : pdrom_top

// ===== dv/tb_program_and_data_rom_access.sv
`timescale 1ns/1ps
module tb_program_and_data_rom_access;
   logic        mclk                    = 1'b0;
   logic        rst                     = 1'b1;
   logic        unused_fill_ones_option = 1'b1;
   logic        prog_we                 = 1'b0;
   logic [11:0] prog_waddr              = 12'h000;
   logic [11:0] prog_wdata              = 12'h000;
   logic        fetch_reset             = 1'b0;
   logic        fetch_wakeup            = 1'b0;
   logic        fetch_interrupt         = 1'b0;
   logic        fetch_next              = 1'b0;
   logic        rom_addr_we             = 1'b0;
   logic [1:0]  rom_addr_sel            = 2'h0;
   logic [3:0]  rom_addr_wdata          = 4'h0;
   logic [7:0]  data_memory_rom_rdata;
   logic [11:0] fetch_addr, fetch_word;
   logic [3:0]  rom_addr_nibble0, rom_addr_nibble1, rom_addr_nibble2, rom_addr_nibble3;
   logic [15:0] data_memory_rom_addr;
   logic [3:0]  rom_byte_low_nibble, rom_byte_high_nibble;
   logic        rom_data_ready;
   int          mismatches = 0;
   int          tests_run  = 0;
   int          cycles     = 0;
   logic [7:0]  exp_q[$];
   logic [7:0]  mon_exp;
   logic        ready_prev = 1'b1;
   logic [11:0] exp_mem [4096];
   ////////////////////////////////////////////////////////////
   pdrom_top u_pdrom_top (.mclk(mclk), .rst(rst), .unused_fill_ones_option(unused_fill_ones_option),
      .prog_we(prog_we), .prog_waddr(prog_waddr), .prog_wdata(prog_wdata), .fetch_reset(fetch_reset),
      .fetch_wakeup(fetch_wakeup), .fetch_interrupt(fetch_interrupt), .fetch_next(fetch_next),
      .fetch_addr(fetch_addr), .fetch_word(fetch_word), .rom_addr_we(rom_addr_we), .rom_addr_sel(rom_addr_sel),
      .rom_addr_wdata(rom_addr_wdata), .rom_addr_nibble0(rom_addr_nibble0), .rom_addr_nibble1(rom_addr_nibble1),
      .rom_addr_nibble2(rom_addr_nibble2), .rom_addr_nibble3(rom_addr_nibble3),
      .data_memory_rom_addr(data_memory_rom_addr), .data_memory_rom_rdata(data_memory_rom_rdata),
      .rom_byte_low_nibble(rom_byte_low_nibble), .rom_byte_high_nibble(rom_byte_high_nibble),
      .rom_data_ready(rom_data_ready));
   // Byte array stand-in: a pattern that differs between neighbouring addresses, except 7fff and 8000
   function automatic logic [7:0] rom_byte(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction : rom_byte
   assign data_memory_rom_rdata = rom_byte(data_memory_rom_addr);
   always #12.5 mclk = ~mclk;
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] expd);
      tests_run++;
      if (seen !== expd) begin
         mismatches++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, expd);
      end
   endtask : check
   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         give_verdict();
      end
   end
   // Completed fetch shows as a rise of ready; an unexpected rise is a fault in itself
   always @(negedge mclk) begin
      if (!rst && rom_data_ready === 1'b1 && ready_prev !== 1'b1) begin
         if (exp_q.size() == 0) check(16'h0001, 16'h0000);
         else begin
            mon_exp = exp_q.pop_front();
            check(rom_byte_low_nibble, mon_exp[3:0]);
            check(rom_byte_high_nibble, mon_exp[7:4]);
         end
      end
      ready_prev = rom_data_ready;
   end
   ////////////////////////////////////////////////////////////
   task automatic do_reset(input logic opt);
      rst = 1'b1;
      unused_fill_ones_option = opt;
      repeat (6) @(negedge mclk);
      check({fetch_addr, 3'h0, rom_data_ready}, 16'h0001);
      rst = 1'b0;
      repeat (2) @(negedge mclk);
      for (int i = 0; i < 4096; i++) exp_mem[i] = opt ? pdrom_pkg::FILL_ONES : pdrom_pkg::FILL_ZEROS;
   endtask : do_reset
   task automatic prog_wr(input logic [11:0] a, input logic [11:0] d);
      prog_we = 1'b1;
      prog_waddr = a;
      prog_wdata = d;
      exp_mem[a] = d;
      @(negedge mclk);
   endtask : prog_wr
   task automatic fetch(input int kind, input logic [11:0] ea);
      fetch_reset = (kind == 0);
      fetch_wakeup = (kind == 1);
      fetch_interrupt = (kind == 2);
      fetch_next = (kind == 3);
      @(negedge mclk);
      {fetch_reset, fetch_wakeup, fetch_interrupt, fetch_next} = 4'h0;
      check(fetch_addr, ea);
      @(negedge mclk);
      check(fetch_word, exp_mem[ea]);
   endtask : fetch
   task automatic wr_nib(input logic [1:0] sel, input logic [3:0] val);
      rom_addr_we = 1'b1;
      rom_addr_sel = sel;
      rom_addr_wdata = val;
      @(negedge mclk);
   endtask : wr_nib
   // With restart set, nibble 0 is written again while the first fetch is under way
   task automatic rom_read(input logic [15:0] a, input bit restart);
      logic [7:0] old;
      int         n;
      old = {rom_byte_high_nibble, rom_byte_low_nibble};
      for (int i = 0; i < 4; i++) wr_nib(2'(i), a[4*i +: 4]);
      if (restart) begin
         a[3:0] = ~a[3:0];
         wr_nib(2'h0, a[3:0]);
      end
      rom_addr_we = 1'b0;
      exp_q.push_back(rom_byte(a));
      check(data_memory_rom_addr, a);
      check({rom_addr_nibble3, rom_addr_nibble2, rom_addr_nibble1, rom_addr_nibble0}, a);
      check({rom_byte_high_nibble, rom_byte_low_nibble}, old);
      n = 0;
      while (rom_data_ready !== 1'b1 && n < pdrom_pkg::TDRR_FSYS) begin
         @(negedge mclk);
         n++;
      end
      check(rom_data_ready, 1'b1);
      repeat (4) @(negedge mclk);
      check({rom_byte_high_nibble, rom_byte_low_nibble}, rom_byte(a));
   endtask : rom_read
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h8489));
      for (int p = 1; p >= 0; p--) begin
         do_reset(p[0]);
         prog_wr(pdrom_pkg::VEC_RESET, 12'($urandom));
         prog_wr(pdrom_pkg::VEC_WAKEUP, 12'($urandom));
         prog_wr(pdrom_pkg::VEC_INTERRUPT, 12'($urandom));
         prog_wr(12'h009, 12'($urandom));
         prog_wr(pdrom_pkg::PROG_RSV_BASE, 12'($urandom));
         prog_wr(pdrom_pkg::PROG_TOP, 12'($urandom));
         for (int i = 0; i < 4; i++) prog_wr(12'($urandom), 12'($urandom));
         prog_we = 1'b0;
         fetch(0, pdrom_pkg::VEC_RESET);
         fetch(1, pdrom_pkg::VEC_WAKEUP);
         fetch(2, pdrom_pkg::VEC_INTERRUPT);
         for (int a = 9; a <= 4095; a++) fetch(3, 12'(a));
      end
      rom_read(16'hdfc0, 1'b0);
      rom_read(16'hdfff, 1'b1);
      for (int i = 0; i < 8; i++) rom_read(16'($urandom_range(pdrom_pkg::DATA_DEPTH - 1)), i[0]);
      give_verdict();
   end
endmodule : tb_program_and_data_rom_access
